//--- design/rvpq_defs.svh
// register offsets, field positions and reset values of the video pass
// qualifier; included by the qualifier top module and by the testbench
`ifndef RVPQ_DEFS_SVH
`define RVPQ_DEFS_SVH

`define RVPQ_ADDR_ICR   8'h36
`define RVPQ_ADDR_ISR   8'h37
`define RVPQ_ADDR_PSTS  8'h38
`define RVPQ_ADDR_QCTL  8'h39
`define RVPQ_ADDR_CUT   8'h3A

`define RVPQ_RST_ICR    8'h00
`define RVPQ_RST_QCTL   8'h00
`define RVPQ_RST_CUT    8'h00

`define RVPQ_Q_DISCARD  2
`define RVPQ_Q_LSIZE    3
`define RVPQ_Q_LCNT     4
`define RVPQ_Q_PARCLR   5

`define RVPQ_C_LSIZE    0
`define RVPQ_C_FSIZE    1
`define RVPQ_C_PAR      2

`define RVPQ_I_PASS     0
`define RVPQ_I_SYNC     1
`define RVPQ_I_PLOSS    2
`define RVPQ_I_SLOSS    3
`define RVPQ_I_RXINT    4

`define RVPQ_S_LOCK     0
`define RVPQ_S_PASS     1
`define RVPQ_S_LCHG     2
`define RVPQ_S_PCHG     3

`define RVPQ_THR_MAX    2'h3

`endif

//--- design/rvpq_pkg.sv
// types shared by the video pass qualifier
// assumes nothing of its surroundings
package rvpq_pkg;

    typedef enum logic [2:0] {
        rvpq_fwd_idle  = 3'h1,
        rvpq_fwd_frame = 3'h2,
        rvpq_fwd_cut   = 3'h4
    } rvpq_fwd_t;

endpackage

//--- design/rvpq_top.sv
// receive port video qualification, frame cut-off and receive port status
// assumes video and lock arrive on link_clk; registers on clk
`timescale 1ns/10ps
`include "rvpq_defs.svh"

module rvpq_top (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       ext_sync,
    output logic            irq,
    input  wire logic       link_clk,
    input  wire logic       in_lock,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    input  wire logic       in_fs,
    input  wire logic       in_fe,
    input  wire logic       in_le,
    input  wire logic       in_par_err,
    output logic            out_valid,
    output logic      [7:0] out_data,
    output logic            out_fs,
    output logic            out_fe,
    output logic            out_le,
    output logic            rx_pass
);

    // register side
    logic [7:0] icr;
    logic [7:0] isr;
    logic [7:0] qctl;
    logic [7:0] cut;
    logic       lock_chg;
    logic       pass_chg;
    logic       pass_s1;
    logic       pass_s2;
    logic       pass_d;
    logic       lock_s1;
    logic       lock_s2;
    logic       lock_d;
    logic       sync_d;
    logic [7:0] isr_set;
    logic       rd_isr;
    logic       rd_psts;

    // link side
    logic       lrst_a;
    logic       lrst_n;
    logic [7:0] q_s1;
    logic [7:0] q_s2;
    logic [7:0] c_s1;
    logic [7:0] c_s2;
    logic [1:0] thr;
    logic       discard_en;
    logic       lsize_en;
    logic       lcnt_en;
    logic       parclr_en;
    logic [15:0] len_cnt;
    logic [15:0] ref_len;
    logic       ref_len_ok;
    logic [15:0] line_cnt;
    logic [15:0] ref_cnt;
    logic       ref_cnt_ok;
    logic [15:0] line_bytes;
    logic [15:0] lines;
    logic       frame_in;
    logic       frame_ok;
    logic       len_chg_ev;
    logic       cnt_chg_ev;
    logic       cnt_over_ev;
    logic       par_clr_ev;
    logic       good_end;
    logic [1:0] valid_cnt;
    logic [1:0] next_cnt;
    logic [1:0] eff_thr;
    logic       par_early;
    logic       drop;
    logic       cut_ev;
    rvpq_pkg::rvpq_fwd_t fwd_st;

    // register access
    assign rd_isr  = reg_rd && (reg_addr == `RVPQ_ADDR_ISR);
    assign rd_psts = reg_rd && (reg_addr == `RVPQ_ADDR_PSTS);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            icr  <= `RVPQ_RST_ICR;
            qctl <= `RVPQ_RST_QCTL;
            cut  <= `RVPQ_RST_CUT;
        end else if (reg_wr) begin
            if (reg_addr == `RVPQ_ADDR_ICR)
                icr <= reg_wdata;
            if (reg_addr == `RVPQ_ADDR_QCTL)
                qctl <= reg_wdata;
            if (reg_addr == `RVPQ_ADDR_CUT)
                cut <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `RVPQ_ADDR_ICR:  reg_rdata <= icr;
                `RVPQ_ADDR_ISR:  reg_rdata <= isr;
                `RVPQ_ADDR_PSTS: reg_rdata <= {4'h0, pass_chg, lock_chg,
                                               pass_s2, lock_s2};
                `RVPQ_ADDR_QCTL: reg_rdata <= qctl;
                `RVPQ_ADDR_CUT:  reg_rdata <= cut;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    // pass and lock into the register domain
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pass_s1 <= 1'b0;
            pass_s2 <= 1'b0;
            pass_d  <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            lock_d  <= 1'b0;
            sync_d  <= 1'b0;
        end else begin
            pass_s1 <= rx_pass;
            pass_s2 <= pass_s1;
            pass_d  <= pass_s2;
            lock_s1 <= in_lock;
            lock_s2 <= lock_s1;
            lock_d  <= lock_s2;
            sync_d  <= ext_sync;
        end
    end

    // port change events, held until the status is read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lock_chg <= 1'b0;
            pass_chg <= 1'b0;
        end else begin
            lock_chg <= (lock_s2 != lock_d) || (lock_chg && !rd_psts);
            pass_chg <= (pass_s2 != pass_d) || (pass_chg && !rd_psts);
        end
    end

    always_comb begin
        isr_set = 8'h00;
        isr_set[`RVPQ_I_PASS]  = pass_s2 && !pass_d;
        isr_set[`RVPQ_I_SYNC]  = ext_sync && !sync_d;
        isr_set[`RVPQ_I_PLOSS] = !pass_s2 && pass_d;
        isr_set[`RVPQ_I_SLOSS] = !ext_sync && sync_d;
        isr_set[`RVPQ_I_RXINT] = (lock_s2 != lock_d) || (pass_s2 != pass_d);
    end

    // status sets regardless of enables; a set beats a read clear
    always_ff @(posedge clk) begin
        if (!rstn)
            isr <= 8'h00;
        else
            isr <= (rd_isr ? 8'h00 : isr) | isr_set;
    end

    always_ff @(posedge clk) begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= |(isr & icr);
    end

    a_isr_sources: assert property (@(posedge clk) disable iff (!rstn)
        isr[7:5] == 3'h0) else $error("unused status bit set");
    a_isr_set_wins: assert property (@(posedge clk) disable iff (!rstn)
        (pass_s2 && !pass_d) |=> isr[`RVPQ_I_PASS])
        else $error("pass event lost");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
        ((isr & icr) == 8'h00) |=> !irq)
        else $error("interrupt without enabled status");
    a_event_held: assert property (@(posedge clk) disable iff (!rstn)
        (lock_chg && !rd_psts) |=> lock_chg)
        else $error("lock event dropped before read");

    // link domain reset and quasi-static controls
    always_ff @(posedge link_clk) begin
        lrst_a <= rstn;
        lrst_n <= lrst_a;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            q_s1 <= `RVPQ_RST_QCTL;
            q_s2 <= `RVPQ_RST_QCTL;
            c_s1 <= `RVPQ_RST_CUT;
            c_s2 <= `RVPQ_RST_CUT;
        end else begin
            q_s1 <= qctl;
            q_s2 <= q_s1;
            c_s1 <= cut;
            c_s2 <= c_s1;
        end
    end

    assign thr        = q_s2[1:0];
    assign discard_en = q_s2[`RVPQ_Q_DISCARD];
    assign lsize_en   = q_s2[`RVPQ_Q_LSIZE];
    assign lcnt_en    = q_s2[`RVPQ_Q_LCNT];
    assign parclr_en  = q_s2[`RVPQ_Q_PARCLR];

    // line length and line count measurement
    assign line_bytes = len_cnt + (in_valid ? 16'h0001 : 16'h0000);
    assign lines      = line_cnt + (in_le ? 16'h0001 : 16'h0000);
    assign len_chg_ev = in_le && ref_len_ok && (line_bytes != ref_len);
    assign cnt_chg_ev = in_fe && ref_cnt_ok && (lines != ref_cnt);
    assign cnt_over_ev = in_le && ref_cnt_ok && (lines > ref_cnt);
    assign par_clr_ev = in_par_err && parclr_en;

    always_ff @(posedge link_clk) begin
        if (!lrst_n || !in_lock) begin
            len_cnt    <= 16'h0000;
            ref_len    <= 16'h0000;
            ref_len_ok <= 1'b0;
        end else if (in_le) begin
            len_cnt    <= 16'h0000;
            ref_len    <= line_bytes;
            ref_len_ok <= 1'b1;
        end else if (in_valid) begin
            len_cnt <= line_bytes;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n || !in_lock) begin
            line_cnt   <= 16'h0000;
            ref_cnt    <= 16'h0000;
            ref_cnt_ok <= 1'b0;
        end else if (in_fs) begin
            line_cnt <= 16'h0000;
        end else if (in_fe) begin
            line_cnt   <= 16'h0000;
            ref_cnt    <= lines;
            ref_cnt_ok <= 1'b1;
        end else if (in_le) begin
            line_cnt <= lines;
        end
    end

    // a frame is good with no parity error and consistent selected sizes
    always_ff @(posedge link_clk) begin
        if (!lrst_n || !in_lock) begin
            frame_in <= 1'b0;
            frame_ok <= 1'b0;
        end else if (in_fs) begin
            frame_in <= 1'b1;
            frame_ok <= !in_par_err;
        end else begin
            if (in_fe)
                frame_in <= 1'b0;
            if (in_par_err || (len_chg_ev && lsize_en))
                frame_ok <= 1'b0;
        end
    end

    assign good_end = in_fe && frame_in && frame_ok && !in_par_err
                      && !(len_chg_ev && lsize_en)
                      && !(cnt_chg_ev && lcnt_en);

    always_comb begin
        next_cnt = valid_cnt;
        if (!in_lock)
            next_cnt = 2'h0;
        else if (par_clr_ev)
            next_cnt = 2'h0;
        else if (len_chg_ev && lsize_en)
            next_cnt = 2'h0;
        else if (cnt_chg_ev && lcnt_en)
            next_cnt = 2'h0;
        else if (in_fe && !good_end)
            next_cnt = 2'h0;
        else if (good_end && valid_cnt != `RVPQ_THR_MAX)
            next_cnt = valid_cnt + 2'h1;
    end

    // after a parity error with parclr_en set the target is one frame lower
    assign eff_thr = (par_early && thr != 2'h0) ? thr - 2'h1 : thr;

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            valid_cnt <= 2'h0;
            rx_pass   <= 1'b0;
            par_early <= 1'b0;
        end else begin
            valid_cnt <= next_cnt;
            if (!in_lock || par_clr_ev)
                rx_pass <= 1'b0;
            else if (thr == 2'h0)
                rx_pass <= 1'b1;
            else
                rx_pass <= next_cnt >= eff_thr;
            if (par_clr_ev)
                par_early <= 1'b1;
            else if (!in_lock || next_cnt >= thr)
                par_early <= 1'b0;
        end
    end

    // forwarding with discard and cut-off
    assign drop   = discard_en && !rx_pass;
    assign cut_ev = (len_chg_ev && c_s2[`RVPQ_C_LSIZE])
                    || ((cnt_chg_ev || cnt_over_ev) && c_s2[`RVPQ_C_FSIZE])
                    || (in_par_err && c_s2[`RVPQ_C_PAR])
                    || drop || !in_lock;

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            fwd_st    <= rvpq_pkg::rvpq_fwd_idle;
            out_valid <= 1'b0;
            out_fs    <= 1'b0;
            out_fe    <= 1'b0;
            out_le    <= 1'b0;
            out_data  <= 8'h00;
        end else begin
            out_valid <= 1'b0;
            out_fs    <= 1'b0;
            out_fe    <= 1'b0;
            out_le    <= 1'b0;
            out_data  <= in_data;
            unique case (fwd_st)
                rvpq_pkg::rvpq_fwd_idle, rvpq_pkg::rvpq_fwd_cut: begin
                    if (in_fs && !drop && in_lock) begin
                        out_fs <= 1'b1;
                        fwd_st <= rvpq_pkg::rvpq_fwd_frame;
                    end
                end
                rvpq_pkg::rvpq_fwd_frame: begin
                    if (cut_ev) begin
                        fwd_st <= rvpq_pkg::rvpq_fwd_cut;
                    end else if (in_fs) begin
                        out_fs <= 1'b1;
                    end else begin
                        out_valid <= in_valid;
                        out_le    <= in_le;
                        if (in_fe) begin
                            out_fe <= 1'b1;
                            fwd_st <= rvpq_pkg::rvpq_fwd_idle;
                        end
                    end
                end
            endcase
        end
    end

    a_par_clears: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (par_clr_ev && in_lock) |=> (!rx_pass && valid_cnt == 2'h0))
        else $error("parity error kept pass");
    a_lock_loss: assert property (@(posedge link_clk) disable iff (!lrst_n)
        !in_lock |=> (!rx_pass && valid_cnt == 2'h0))
        else $error("pass held without lock");
    a_thr_zero: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (in_lock && thr == 2'h0 && !par_clr_ev) |=> rx_pass)
        else $error("no pass at lock with zero threshold");
    a_pass_thr: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (rx_pass && $past(q_s2) == q_s2 && q_s2[1:0] != 2'h0
         && !$past(par_early)) |-> valid_cnt >= q_s2[1:0])
        else $error("pass below threshold");
    a_len_reset: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (len_chg_ev && lsize_en) |=> valid_cnt == 2'h0)
        else $error("line length change kept count");
    a_cnt_reset: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (cnt_chg_ev && lcnt_en) |=> valid_cnt == 2'h0)
        else $error("line count change kept count");
    a_discard_drop: assert property (@(posedge link_clk)
        disable iff (!lrst_n)
        (drop && fwd_st != rvpq_pkg::rvpq_fwd_frame) |=> !out_fs)
        else $error("frame started while discarding");
    a_cut_no_end: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (fwd_st == rvpq_pkg::rvpq_fwd_cut) |=> (!out_fe && !out_valid))
        else $error("data or frame end after cut");
    a_par_cut: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (fwd_st == rvpq_pkg::rvpq_fwd_frame && in_par_err
         && c_s2[`RVPQ_C_PAR]) |=> (fwd_st == rvpq_pkg::rvpq_fwd_cut
         && !out_valid && !out_fe))
        else $error("parity error not cut");
    a_restart_fs: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (fwd_st == rvpq_pkg::rvpq_fwd_cut && in_fs && !drop && in_lock)
        |=> out_fs) else $error("no fresh frame start");

endmodule

//--- verif/rvpq_src.sv
// upstream video source model driving the receive side of the qualifier
// assumes link_clk runs while the link is up; drives on its rising edge
`timescale 1ns/10ps

module rvpq_src (
    input  wire logic       link_clk,
    output logic            lock,
    output logic            valid,
    output logic      [7:0] data,
    output logic            fs,
    output logic            fe,
    output logic            le,
    output logic            par_err
);
    initial begin
        lock    = 1'b0;
        valid   = 1'b0;
        data    = 8'h00;
        fs      = 1'b0;
        fe      = 1'b0;
        le      = 1'b0;
        par_err = 1'b0;
    end

    task automatic set_lock(input logic v);
        @(posedge link_clk);
        lock <= v;
    endtask

    // idle cycle: data toggles so stale bytes never look valid
    task automatic idle();
        @(posedge link_clk);
        valid   <= 1'b0;
        le      <= 1'b0;
        fs      <= 1'b0;
        fe      <= 1'b0;
        par_err <= 1'b0;
        data    <= ~data;
    endtask

    // nl lines of ll bytes; parity pulse on first byte of line perr
    task automatic frame(input int nl, input int ll, input int perr);
        @(posedge link_clk);
        fs <= 1'b1;
        idle();
        for (int l = 0; l < nl; l++) begin
            for (int b = 0; b < ll; b++) begin
                @(posedge link_clk);
                valid   <= 1'b1;
                data    <= 8'((l << 4) + b);
                le      <= (b == ll - 1);
                par_err <= (l == perr) && (b == 0);
            end
            idle();
        end
        @(posedge link_clk);
        fe <= 1'b1;
        repeat (4) idle();
    endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the video pass qualifier top module
// assumes the register offsets and field layout of rvpq_defs.svh
`timescale 1ns/10ps
`include "rvpq_defs.svh"

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    err_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end

module testbench;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       ext_sync = 1'b0;
    logic       irq;
    logic       in_lock, in_valid, in_fs, in_fe, in_le, in_par_err;
    logic [7:0] in_data;
    logic       out_valid, out_fs, out_fe, out_le, rx_pass;
    logic [7:0] out_data;
    int         err_count = 0;
    int         total_checks = 0;
    int         fs_n = 0;
    int         fe_n = 0;
    int         vb_n = 0;
    int         le_n = 0;
    int         susp_n = 0;
    logic       open_f = 1'b0;
    logic [7:0] le_d = 8'h00;

    always #2 clk = ~clk;
    always #7.5 link_clk = ~link_clk;

    rvpq_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .ext_sync(ext_sync), .irq(irq),
        .link_clk(link_clk), .in_lock(in_lock), .in_valid(in_valid),
        .in_data(in_data), .in_fs(in_fs), .in_fe(in_fe), .in_le(in_le),
        .in_par_err(in_par_err), .out_valid(out_valid),
        .out_data(out_data), .out_fs(out_fs), .out_fe(out_fe),
        .out_le(out_le), .rx_pass(rx_pass));

    rvpq_src src (.link_clk(link_clk), .lock(in_lock), .valid(in_valid),
        .data(in_data), .fs(in_fs), .fe(in_fe), .le(in_le),
        .par_err(in_par_err));

    always @(posedge link_clk) begin
        if (out_fs === 1'b1) fs_n++;
        if (out_fe === 1'b1) fe_n++;
        if (out_valid === 1'b1) vb_n++;
        if (out_le === 1'b1) begin
            le_n++;
            le_d = out_data;
        end
        // downstream view: a start while a frame is open marks it suspect
        if (out_fs === 1'b1 && open_f) susp_n++;
        if (out_fs === 1'b1) open_f = 1'b1;
        if (out_fe === 1'b1) open_f = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask

    task automatic lw(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask

    task automatic fr(input int nl, input int ll, input int perr);
        fs_n = 0;
        fe_n = 0;
        vb_n = 0;
        le_n = 0;
        src.frame(nl, ll, perr);
        lw(6);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic t_regs();
        rd(`RVPQ_ADDR_ICR, `RVPQ_RST_ICR, "icr reset");
        rd(`RVPQ_ADDR_QCTL, `RVPQ_RST_QCTL, "qctl reset");
        rd(`RVPQ_ADDR_CUT, `RVPQ_RST_CUT, "cut reset");
        rd(8'h50, 8'h00, "unmapped");
        wr(`RVPQ_ADDR_ICR, 8'h1F);
        rd(`RVPQ_ADDR_ICR, 8'h1F, "icr rw");
        wr(`RVPQ_ADDR_ICR, 8'h00);
    endtask

    task automatic t_lock();
        src.set_lock(1'b1);
        lw(8);
        `CHK("pass on lock", 1'b1, rx_pass)
        repeat (8) @(posedge clk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        wr(`RVPQ_ADDR_ICR, 8'h1F);
        repeat (3) @(posedge clk);
        #1;
        `CHK("irq enabled", 1'b1, irq)
        rd(`RVPQ_ADDR_ISR, 8'h11, "isr pass rose");
        rd(`RVPQ_ADDR_PSTS, 8'h0F, "port events");
        rd(`RVPQ_ADDR_PSTS, 8'h03, "port held");
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        @(posedge clk);
        ext_sync <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`RVPQ_ADDR_ISR, 8'h02, "isr sync rose");
        @(posedge clk);
        ext_sync <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`RVPQ_ADDR_ISR, 8'h08, "isr sync fell");
        src.set_lock(1'b0);
        lw(8);
        `CHK("pass on lock loss", 1'b0, rx_pass)
        rd(`RVPQ_ADDR_ISR, 8'h14, "isr pass fell");
        wr(`RVPQ_ADDR_ICR, 8'h00);
    endtask

    task automatic t_qual();
        wr(`RVPQ_ADDR_QCTL, 8'h0E);
        lw(4);
        src.set_lock(1'b1);
        lw(8);
        `CHK("no pass at lock", 1'b0, rx_pass)
        fr(2, 4, -1);
        `CHK("one frame", 1'b0, rx_pass)
        fr(2, 4, -1);
        `CHK("two frames", 1'b1, rx_pass)
        `CHK("discarded", 0, fs_n)
        fr(2, 4, -1);
        `CHK("fwd fs", 1, fs_n)
        `CHK("fwd fe", 1, fe_n)
        `CHK("fwd bytes", 8, vb_n)
        `CHK("fwd le", 2, le_n)
        `CHK("fwd last byte", 8'h13, le_d)
        wr(`RVPQ_ADDR_CUT, 8'h01);
        lw(4);
        fr(2, 5, -1);
        `CHK("cut no fe", 0, fe_n)
        `CHK("len change", 1'b0, rx_pass)
        fr(2, 5, -1);
        fr(2, 5, -1);
        `CHK("requalified", 1'b1, rx_pass)
        fr(2, 5, -1);
        `CHK("fresh fs", 1, fs_n)
        `CHK("fresh fe", 1, fe_n)
        `CHK("repeat fs", 1, susp_n)
    endtask

    task automatic t_parity();
        wr(`RVPQ_ADDR_QCTL, 8'h2E);
        wr(`RVPQ_ADDR_CUT, 8'h04);
        lw(4);
        fr(3, 5, 1);
        `CHK("parity drop", 1'b0, rx_pass)
        `CHK("parity cut fe", 0, fe_n)
        `CHK("parity cut fs", 1, fs_n)
        fr(2, 5, -1);
        `CHK("early pass", 1'b1, rx_pass)
        `CHK("early no fwd", 0, fs_n)
    endtask

    task automatic t_lcnt();
        wr(`RVPQ_ADDR_QCTL, 8'h16);
        wr(`RVPQ_ADDR_CUT, 8'h02);
        lw(4);
        fr(2, 5, -1);
        fr(2, 5, -1);
        `CHK("lcnt pass", 1'b1, rx_pass)
        fr(3, 5, -1);
        `CHK("lcnt drop", 1'b0, rx_pass)
        `CHK("lcnt cut fe", 0, fe_n)
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        lw(5);
        t_regs();
        t_lock();
        t_qual();
        t_parity();
        t_lcnt();
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
